/* hw/ric_map.svh */
`ifndef RIC_MAP_SVH
`define RIC_MAP_SVH

`define RIC_ADDR_W 16
`define RIC_DATA_W 8

`define RIC_OFF_POWER_DOWN 16'h0a01
`define RIC_OFF_VALID_SKIP 16'h0a02
`define RIC_OFF_FORCE_FAULT 16'h0a03
`define RIC_OFF_MON_BYPASS 16'h0a04
`define RIC_OFF_GROUP_CLR 16'h0a05
`define RIC_OFF_SYSMEM_CLR 16'h0a06
`define RIC_OFF_REF_AB_CLR 16'h0a07
`define RIC_OFF_REF_CD_CLR 16'h0a08

// Sticky status words, same layout as the matching clear words
`define RIC_OFF_SYSMEM_STAT 16'h0b05
`define RIC_OFF_REF_AB_STAT 16'h0b06
`define RIC_OFF_REF_CD_STAT 16'h0b07
`define RIC_OFF_MISC_STAT 16'h0b08
`define RIC_OFF_SYSMEM_MASK 16'h0b15
`define RIC_OFF_REF_AB_MASK 16'h0b16
`define RIC_OFF_REF_CD_MASK 16'h0b17
`define RIC_OFF_MISC_MASK 16'h0b18

`define RIC_REF_CTRL_RESET 4'h0
`define RIC_BYTE_RESET 8'h00

`define RIC_GRP_ALL 0
`define RIC_GRP_COMMON 1
`define RIC_GRP_LOOP_FIRST 2
`define RIC_GRP_LOOP_SECOND 3
`define RIC_GRP_WDOG_ALERT 7

// Implemented bits of each status word
`define RIC_SYSMEM_BITS 8'h7b
`define RIC_REF_BITS 8'h77
`define RIC_MISC_BITS 8'h01

`define RIC_NUM_STAT 4

`endif

/* hw/ric_pkg.sv */
package ric_pkg;
  typedef logic [7:0] ric_byte_t;
  typedef logic [3:0] ric_ref_t;
  typedef logic [15:0] ric_addr_t;
  typedef enum logic [1:0] {
    RIC_ST_SYSMEM,
    RIC_ST_REF_AB,
    RIC_ST_REF_CD,
    RIC_ST_MISC
  } ric_stat_e;
endpackage

/* hw/ric_ctrl.sv */
`timescale 1ns/100ps
`include "ric_map.svh"
// How it works
// - Skip write with reference unfaulted pulses its validation timer to zero.
// - Skip bits self-clear after a write and reset to zero.
// - Forced-fault bit set marks that reference faulted and unused.
// - Monitor-bypass bit set bypasses that reference's frequency monitor.
// - Reserved bits 7:4 of reference control words reset and read zero.
// - Writing one to a clear bit resets the matching latched status bit.
// - Every clear bit self-clears after being written as one.
// - Clear bit n acts on status bit n of the matching word.
// - Group clear: bit0 all, bit1 common, bit2/3 loop groups; 6:4 reserved.
// - Group clear bit 7 clears the watchdog timer alert.
// - System clock PLL clears: bit6 unlocked, bit5 stable, bit4 locked.
// - Bit 3 clears watchdog expiry interrupt; bits 7 and 2 reserved.
// - Bit 1 clears memory fault, bit 0 memory completion.
// - Refs first/second clears at bits 0-2 and 4-6; 3,7 reserved.
// - Refs third/fourth clears at bits 0-2 and 4-6; 3,7 reserved.
// - Power-down bit set powers down that reference receiver.
module ric_ctrl
  import ric_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ric_addr_t reg_addr,
  input wire ric_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ric_byte_t reg_rdata,
  input wire ric_ref_t ref_faulted,
  input wire ric_byte_t sysmem_evt,
  input wire ric_byte_t ref_ab_evt,
  input wire ric_byte_t ref_cd_evt,
  input wire logic wdog_alert_evt,
  output ric_ref_t ref_power_down,
  output ric_ref_t ref_force_fault,
  output ric_ref_t ref_monitor_bypass,
  output ric_ref_t ref_timer_zero,
  output logic loop_first_irq_clear,
  output logic loop_second_irq_clear,
  output logic irq
);

  function automatic logic hit(input ric_addr_t a, input ric_addr_t off);
    hit = (a == off);
  endfunction

  ric_ref_t power_down_ff;
  ric_ref_t force_fault_ff;
  ric_ref_t mon_bypass_ff;
  ric_ref_t timer_zero_ff;
  logic loop_first_ff;
  logic loop_second_ff;
  ric_byte_t rdata_ff;
  ric_byte_t nxt_rdata;
  ric_byte_t stat_ff [`RIC_NUM_STAT];
  ric_byte_t mask_ff [`RIC_NUM_STAT];
  ric_byte_t evt [`RIC_NUM_STAT];
  ric_byte_t impl_bits [`RIC_NUM_STAT];
  ric_byte_t clr [`RIC_NUM_STAT];
  ric_addr_t off_clr [`RIC_NUM_STAT];
  ric_addr_t off_stat [`RIC_NUM_STAT];
  ric_addr_t off_mask [`RIC_NUM_STAT];
  logic grp_wr;
  logic [`RIC_NUM_STAT-1:0] pend;

  assign grp_wr = reg_wr && hit(reg_addr, `RIC_OFF_GROUP_CLR);

  assign evt[RIC_ST_SYSMEM] = sysmem_evt;
  assign evt[RIC_ST_REF_AB] = ref_ab_evt;
  assign evt[RIC_ST_REF_CD] = ref_cd_evt;
  assign evt[RIC_ST_MISC] = {7'h00, wdog_alert_evt};

  assign impl_bits[RIC_ST_SYSMEM] = `RIC_SYSMEM_BITS;
  assign impl_bits[RIC_ST_REF_AB] = `RIC_REF_BITS;
  assign impl_bits[RIC_ST_REF_CD] = `RIC_REF_BITS;
  assign impl_bits[RIC_ST_MISC] = `RIC_MISC_BITS;

  // Misc word has no clear register of its own; group bit 7 serves it
  assign off_clr[RIC_ST_SYSMEM] = `RIC_OFF_SYSMEM_CLR;
  assign off_clr[RIC_ST_REF_AB] = `RIC_OFF_REF_AB_CLR;
  assign off_clr[RIC_ST_REF_CD] = `RIC_OFF_REF_CD_CLR;
  assign off_clr[RIC_ST_MISC] = `RIC_OFF_GROUP_CLR;

  assign off_stat[RIC_ST_SYSMEM] = `RIC_OFF_SYSMEM_STAT;
  assign off_stat[RIC_ST_REF_AB] = `RIC_OFF_REF_AB_STAT;
  assign off_stat[RIC_ST_REF_CD] = `RIC_OFF_REF_CD_STAT;
  assign off_stat[RIC_ST_MISC] = `RIC_OFF_MISC_STAT;

  assign off_mask[RIC_ST_SYSMEM] = `RIC_OFF_SYSMEM_MASK;
  assign off_mask[RIC_ST_REF_AB] = `RIC_OFF_REF_AB_MASK;
  assign off_mask[RIC_ST_REF_CD] = `RIC_OFF_REF_CD_MASK;
  assign off_mask[RIC_ST_MISC] = `RIC_OFF_MISC_MASK;

  // Per-word clear vector from the clear words, group word and w1c
  always_comb begin
    for (int k = 0; k < `RIC_NUM_STAT; k++) begin
      clr[k] = `RIC_BYTE_RESET;
      if (reg_wr && hit(reg_addr, off_stat[k])) begin
        clr[k] = reg_wdata;
      end
      if (grp_wr && reg_wdata[`RIC_GRP_ALL]) begin
        clr[k] = 8'hff;
      end
    end
    for (int k = 0; k < `RIC_NUM_STAT - 1; k++) begin
      if (reg_wr && hit(reg_addr, off_clr[k])) begin
        clr[k] = clr[k] | reg_wdata;
      end
      if (grp_wr && reg_wdata[`RIC_GRP_COMMON]) begin
        clr[k] = 8'hff;
      end
    end
    if (grp_wr && reg_wdata[`RIC_GRP_WDOG_ALERT]) begin
      clr[RIC_ST_MISC] = clr[RIC_ST_MISC] | 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RIC_NUM_STAT; g++) begin : g_stat
      // Event in the clearing cycle wins so no edge is lost
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stat_ff[g] <= `RIC_BYTE_RESET;
        end else begin
          stat_ff[g] <= ((stat_ff[g] & ~clr[g]) | evt[g]) & impl_bits[g];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mask_ff[g] <= `RIC_BYTE_RESET;
        end else if (reg_wr && hit(reg_addr, off_mask[g])) begin
          mask_ff[g] <= reg_wdata & impl_bits[g];
        end
      end

      assign pend[g] = |(stat_ff[g] & mask_ff[g]);
    end
  endgenerate

  assign irq = |pend;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_down_ff <= `RIC_REF_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, `RIC_OFF_POWER_DOWN)) begin
      power_down_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      force_fault_ff <= `RIC_REF_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, `RIC_OFF_FORCE_FAULT)) begin
      force_fault_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mon_bypass_ff <= `RIC_REF_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, `RIC_OFF_MON_BYPASS)) begin
      mon_bypass_ff <= reg_wdata[3:0];
    end
  end

  // One-cycle pulses; nothing is stored, so the skip bits read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_zero_ff <= `RIC_REF_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, `RIC_OFF_VALID_SKIP)) begin
      timer_zero_ff <= reg_wdata[3:0] & ~(ref_faulted | force_fault_ff);
    end else begin
      timer_zero_ff <= `RIC_REF_CTRL_RESET;
    end
  end

  // Loop groups live outside; they get a one-cycle clear request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loop_first_ff <= 1'b0;
      loop_second_ff <= 1'b0;
    end else begin
      loop_first_ff <= grp_wr && (reg_wdata[`RIC_GRP_LOOP_FIRST] || reg_wdata[`RIC_GRP_ALL]);
      loop_second_ff <= grp_wr && (reg_wdata[`RIC_GRP_LOOP_SECOND] || reg_wdata[`RIC_GRP_ALL]);
    end
  end

  // Clear and skip words are not decoded here, so they read zero
  always_comb begin
    nxt_rdata = `RIC_BYTE_RESET;
    if (hit(reg_addr, `RIC_OFF_POWER_DOWN)) begin
      nxt_rdata = {4'h0, power_down_ff};
    end
    if (hit(reg_addr, `RIC_OFF_FORCE_FAULT)) begin
      nxt_rdata = {4'h0, force_fault_ff};
    end
    if (hit(reg_addr, `RIC_OFF_MON_BYPASS)) begin
      nxt_rdata = {4'h0, mon_bypass_ff};
    end
    for (int k = 0; k < `RIC_NUM_STAT; k++) begin
      if (hit(reg_addr, off_stat[k])) begin
        nxt_rdata = stat_ff[k];
      end
      if (hit(reg_addr, off_mask[k])) begin
        nxt_rdata = mask_ff[k];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= `RIC_BYTE_RESET;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `RIC_BYTE_RESET;
    end
  end

  assign reg_rdata = rdata_ff;
  assign ref_power_down = power_down_ff;
  assign ref_force_fault = force_fault_ff;
  assign ref_monitor_bypass = mon_bypass_ff;
  assign ref_timer_zero = timer_zero_ff;
  assign loop_first_irq_clear = loop_first_ff;
  assign loop_second_irq_clear = loop_second_ff;

endmodule

/* sim/ric_ctrl_assertions.sv */
`timescale 1ns/100ps
module ric_ctrl_assertions
  import ric_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ric_addr_t reg_addr,
  input wire ric_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ric_byte_t reg_rdata,
  input wire ric_ref_t ref_faulted,
  input wire ric_byte_t sysmem_evt,
  input wire ric_byte_t ref_ab_evt,
  input wire ric_byte_t ref_cd_evt,
  input wire logic wdog_alert_evt,
  input wire ric_ref_t ref_power_down,
  input wire ric_ref_t ref_force_fault,
  input wire ric_ref_t ref_monitor_bypass,
  input wire ric_ref_t ref_timer_zero,
  input wire logic loop_first_irq_clear,
  input wire logic loop_second_irq_clear,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic skip_wr = reg_wr && reg_addr == 16'h0a02;
  wire logic grp_wr = reg_wr && reg_addr == 16'h0a05;
  // Events win over clears, so clear-all is judged only on quiet cycles
  wire logic quiet = !wdog_alert_evt && (sysmem_evt | ref_ab_evt | ref_cd_evt) == 8'h00;
  a_skip_pulse: assert property (skip_wr |=> {4'h0, ref_timer_zero} ==
    ($past(reg_wdata) & 8'h0f & ~{4'h0, $past(ref_faulted) | $past(ref_force_fault)})) else $error("timer pulse wrong");
  a_skip_idle: assert property (!skip_wr |=> ref_timer_zero == 4'h0) else $error("timer pulse stuck");
  a_fault_write: assert property (reg_wr && reg_addr == 16'h0a03 |=>
    {4'h0, ref_force_fault} == ($past(reg_wdata) & 8'h0f)) else $error("forced fault not written");
  a_fault_hold: assert property (!(reg_wr && reg_addr == 16'h0a03) |=> $stable(ref_force_fault))
    else $error("forced fault changed");
  a_bypass_write: assert property (reg_wr && reg_addr == 16'h0a04 |=>
    {4'h0, ref_monitor_bypass} == ($past(reg_wdata) & 8'h0f)) else $error("bypass not written");
  a_pdown_write: assert property (reg_wr && reg_addr == 16'h0a01 |=>
    {4'h0, ref_power_down} == ($past(reg_wdata) & 8'h0f)) else $error("power down not written");
  a_selfclr_read: assert property (reg_rd && reg_addr inside {16'h0a02, [16'h0a05:16'h0a08]} |=>
    reg_rdata == 8'h00) else $error("self clearing word read nonzero");
  a_fault_readback: assert property (reg_rd && reg_addr == 16'h0a03 |=>
    reg_rdata == {4'h0, $past(ref_force_fault)}) else $error("forced fault readback wrong");
  a_loop_pulse: assert property (grp_wr |=> loop_first_irq_clear == ($past(reg_wdata[0]) | $past(reg_wdata[2])) &&
    loop_second_irq_clear == ($past(reg_wdata[0]) | $past(reg_wdata[3]))) else $error("loop clear pulse wrong");
  a_loop_idle: assert property (!grp_wr |=> !loop_first_irq_clear && !loop_second_irq_clear)
    else $error("loop clear stuck");
  a_clear_all: assert property (grp_wr && reg_wdata[0] && quiet |=> !irq) else $error("clear all left irq");
  a_irq_sticky: assert property (irq && !reg_wr |=> irq) else $error("irq dropped without write");
  c_skip: cover property (skip_wr ##1 ref_timer_zero != 4'h0);
  c_clear_all: cover property (grp_wr && reg_wdata[0] && quiet);
  c_irq: cover property ($rose(irq));
endmodule

/* sim/tb.sv */
`timescale 1ns/100ps
module tb;
  import ric_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ric_addr_t reg_addr = 16'h0000;
  ric_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ric_byte_t reg_rdata;
  ric_ref_t ref_faulted = 4'h0;
  ric_byte_t evt [3] = '{8'h00, 8'h00, 8'h00};
  logic wdog_alert_evt = 1'b0;
  ric_ref_t ref_power_down, ref_force_fault, ref_monitor_bypass, ref_timer_zero;
  logic loop_first_irq_clear, loop_second_irq_clear, irq;
  ric_byte_t impl_bits [3] = '{8'h7b, 8'h77, 8'h77};
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  ric_ctrl dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_faulted,
    .sysmem_evt(evt[0]), .ref_ab_evt(evt[1]), .ref_cd_evt(evt[2]), .wdog_alert_evt, .ref_power_down,
    .ref_force_fault, .ref_monitor_bypass, .ref_timer_zero, .loop_first_irq_clear, .loop_second_irq_clear, .irq);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input ric_addr_t a, input ric_byte_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input ric_addr_t a, input ric_byte_t exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic raise(input ric_byte_t v, input logic w);
    @(posedge sys_clk);
    evt <= '{v, v, v};
    wdog_alert_evt <= w;
    @(posedge sys_clk);
    evt <= '{8'h00, 8'h00, 8'h00};
    wdog_alert_evt <= 1'b0;
    #1;
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(16'h0a01, 8'h00);
    rd(16'h0a03, 8'h00);
    rd(16'h0a04, 8'h00);
    wr(16'h0a01, 8'hf9);
    chk("ref_power_down", 8'h09, {4'h0, ref_power_down});
    wr(16'h0a03, 8'hf5);
    chk("ref_force_fault", 8'h05, {4'h0, ref_force_fault});
    rd(16'h0a03, 8'h05);
    wr(16'h0a04, 8'h0a);
    chk("ref_monitor_bypass", 8'h0a, {4'h0, ref_monitor_bypass});
    $display("test control words done");
    @(posedge sys_clk);
    ref_faulted <= 4'h2;
    // Faulted by input and by register both veto the pulse
    wr(16'h0a02, 8'h0f);
    chk("ref_timer_zero", 8'h08, {4'h0, ref_timer_zero});
    @(posedge sys_clk);
    #1;
    chk("ref_timer_zero", 8'h00, {4'h0, ref_timer_zero});
    rd(16'h0a02, 8'h00);
    wr(16'h0c00, 8'hff);
    rd(16'h0c00, 8'h00);
    $display("test skip done");
    for (int i = 0; i < 3; i++) begin
      wr(16'h0b15 + 16'(i), 8'hff);
      raise(8'hff, 1'b0);
      rd(16'h0b05 + 16'(i), impl_bits[i]);
      chk("irq", 8'h01, {7'h00, irq});
      wr(16'h0a06 + 16'(i), 8'h00);
      rd(16'h0b05 + 16'(i), impl_bits[i]);
      wr(16'h0a06 + 16'(i), 8'h01);
      rd(16'h0b05 + 16'(i), impl_bits[i] & 8'hfe);
      wr(16'h0a06 + 16'(i), 8'hff);
      rd(16'h0b05 + 16'(i), 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      // Events reach all three words, so drop this mask before the next word is judged
      wr(16'h0b15 + 16'(i), 8'h00);
    end
    $display("test status words done");
    wr(16'h0b18, 8'h01);
    raise(8'hff, 1'b1);
    wr(16'h0a05, 8'h02);
    rd(16'h0b06, 8'h00);
    rd(16'h0b08, 8'h01);
    wr(16'h0a05, 8'h80);
    rd(16'h0b08, 8'h00);
    wr(16'h0a05, 8'h0c);
    chk("loop clears", 8'h03, {6'h00, loop_second_irq_clear, loop_first_irq_clear});
    raise(8'hff, 1'b1);
    chk("irq", 8'h01, {7'h00, irq});
    wr(16'h0a05, 8'h01);
    chk("loop clears", 8'h03, {6'h00, loop_second_irq_clear, loop_first_irq_clear});
    rd(16'h0b05, 8'h00);
    rd(16'h0b08, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test group clear done");
    give_verdict();
  end
endmodule
bind ric_ctrl ric_ctrl_assertions u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ref_faulted, .sysmem_evt, .ref_ab_evt, .ref_cd_evt, .wdog_alert_evt, .ref_power_down, .ref_force_fault,
  .ref_monitor_bypass, .ref_timer_zero, .loop_first_irq_clear, .loop_second_irq_clear, .irq);
